// ==== logic/cod_decode.v ====
// Opcode decoder and bus cycle engine for the 8-bit core.
// Assumes the sequencer and synchronous memory share core_clk; memory
// returns read data in the same cycle the address is presented.
// Notes on behaviour
// - Free cycle lasts one clock, moves nothing, shows as a read.
// - Program fetch reads the next location; fetch address steps by one.
// - Vector fetch reads the top page, high byte before low byte.
// - A push writes one stack byte; a pop reads one stack byte.
// - Operand reads and writes each move one 8-bit value.
// - 0x00-0x0F: test bit and branch, set even, clear odd, 3 bytes.
// - 0x20 branch always; other 0x2x conditional; two bytes, three cycles.
// - 0x42 multiply five cycles; 0x52 divide six cycles; one byte.
// - 0x82 background debug entry, one byte, five or more cycles.
// - 0x83 software interrupt, eleven cycles, stacking then vector.
// - 0x8E stop, two or more cycles; 0x9E selects second page.
// - 0x8F wait two or more cycles; 0x9F index low to accumulator.
// - 0x3B decrement memory branch nonzero; 0x4B accumulator form.
// - 0x4E/5E/6E/7E memory moves with their own modes and lengths.
// - High nibble A-F picks register/memory mode and cycle count.
`timescale 1ns/100ps
`default_nettype none
`include "cod_consts.vh"
module cod_decode (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        op_valid,
  input  wire [7:0]  op_byte,
  input  wire        cyc_start,
  input  wire [2:0]  cyc_kind,
  input  wire [15:0] cyc_addr,
  input  wire [7:0]  cyc_wdata,
  input  wire [7:0]  vec_offset,
  input  wire        pc_load,
  input  wire [15:0] pc_value,
  input  wire        sp_load,
  input  wire [15:0] sp_value,
  input  wire [7:0]  bus_rdata,
  output reg         dec_valid,
  output reg  [4:0]  dec_class,
  output reg  [3:0]  dec_mode,
  output reg  [1:0]  dec_len,
  output reg  [3:0]  dec_cycles,
  output reg         dec_open_end,
  output reg  [2:0]  dec_bit,
  output reg         dec_illegal,
  output reg         dec_page2,
  output reg         page2_pending,
  output reg  [15:0] bus_addr,
  output reg         bus_rd,
  output reg         bus_wr,
  output reg         bus_xfer,
  output reg  [7:0]  bus_wdata,
  output reg         busy,
  output reg  [7:0]  rdata,
  output reg         rdata_valid,
  output reg  [15:0] vector,
  output reg         vector_valid,
  output reg  [15:0] pc,
  output reg  [15:0] sp
);
  localparam ST_IDLE   = 2'h0;
  localparam ST_VEC_LO = 2'h1;
  localparam ST_VEC_CP = 2'h2;

  wire [4:0] t_cls;
  wire [3:0] t_mode;
  wire [1:0] t_len;
  wire [3:0] t_cyc;
  wire       t_open;
  wire [2:0] t_bit;
  reg  [1:0] state;
  reg        rd_pending;
  reg        vec_hi_pending;

  function [15:0] step16;
    input [15:0] v;
    input        down;
    begin
      step16 = down ? v - `COD_ONE16 : v + `COD_ONE16;
    end
  endfunction

  cod_op_table u_table (
    .op       (op_byte),
    .cls      (t_cls),
    .mode     (t_mode),
    .len      (t_len),
    .cyc      (t_cyc),
    .open_end (t_open),
    .bit_num  (t_bit)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode stage: one registered result per presented opcode byte
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dec_valid <= 1'b0;
      dec_class <= `COD_CL_OTHER;
      dec_mode <= `COD_AM_INH;
      dec_len <= 2'h0;
      dec_cycles <= 4'h0;
      dec_open_end <= 1'b0;
      dec_bit <= 3'h0;
      dec_illegal <= 1'b0;
      dec_page2 <= 1'b0;
      page2_pending <= 1'b0;
    end else begin
      dec_valid <= op_valid;
      if (op_valid) begin
        // Second-page bytes are flagged only; their table lives elsewhere
        dec_page2 <= page2_pending;
        page2_pending <= !page2_pending && op_byte == `COD_PREFIX_OP;
        dec_class <= page2_pending ? `COD_CL_OTHER : t_cls;
        dec_mode <= t_mode;
        dec_len <= t_len;
        dec_cycles <= t_cyc;
        dec_open_end <= t_open;
        dec_bit <= t_bit;
        dec_illegal <= !page2_pending && t_cls == `COD_CL_ILLEGAL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus cycle engine: every cycle kind is one bus clock except the
  // vector fetch, which spends two reads on the top page.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      bus_addr <= 16'h0000;
      bus_rd <= 1'b1;
      bus_wr <= 1'b0;
      bus_xfer <= 1'b0;
      bus_wdata <= 8'h00;
      busy <= 1'b0;
      rd_pending <= 1'b0;
      vec_hi_pending <= 1'b0;
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
      vector <= 16'h0000;
      vector_valid <= 1'b0;
      pc <= `COD_RST_PC;
      sp <= `COD_RST_SP;
    end else begin
      bus_rd <= 1'b1;
      bus_wr <= 1'b0;
      bus_xfer <= 1'b0;
      rd_pending <= 1'b0;
      vec_hi_pending <= 1'b0;
      vector_valid <= 1'b0;
      rdata_valid <= rd_pending;
      if (rd_pending)
        rdata <= bus_rdata;
      if (vec_hi_pending)
        vector[15:8] <= bus_rdata;
      if (pc_load)
        pc <= pc_value;
      if (sp_load)
        sp <= sp_value;
      case (state)
        ST_IDLE: begin
          if (cyc_start) begin
            case (cyc_kind)
              `COD_CY_FREE: begin
                // Read with no transfer: memory sees no strobe
                bus_rd <= 1'b1;
              end
              `COD_CY_PROG: begin
                bus_addr <= pc;
                bus_xfer <= 1'b1;
                rd_pending <= 1'b1;
                if (!pc_load)
                  pc <= step16(pc, 1'b0);
              end
              `COD_CY_READ: begin
                bus_addr <= cyc_addr;
                bus_xfer <= 1'b1;
                rd_pending <= 1'b1;
              end
              `COD_CY_WRITE: begin
                bus_addr <= cyc_addr;
                bus_wdata <= cyc_wdata;
                bus_rd <= 1'b0;
                bus_wr <= 1'b1;
                bus_xfer <= 1'b1;
              end
              `COD_CY_PUSH: begin
                bus_addr <= sp;
                bus_wdata <= cyc_wdata;
                bus_rd <= 1'b0;
                bus_wr <= 1'b1;
                bus_xfer <= 1'b1;
                if (!sp_load)
                  sp <= step16(sp, 1'b1);
              end
              `COD_CY_POP: begin
                bus_addr <= step16(sp, 1'b0);
                bus_xfer <= 1'b1;
                rd_pending <= 1'b1;
                if (!sp_load)
                  sp <= step16(sp, 1'b0);
              end
              `COD_CY_VECTOR: begin
                bus_addr <= {`COD_VEC_PAGE, vec_offset};
                bus_xfer <= 1'b1;
                vec_hi_pending <= 1'b1;
                busy <= 1'b1;
                state <= ST_VEC_LO;
              end
              default: ;
            endcase
          end
        end
        ST_VEC_LO: begin
          // Low byte one above the high byte; never leaves the top page
          bus_addr <= {`COD_VEC_PAGE, bus_addr[7:0] + `COD_ONE8};
          bus_xfer <= 1'b1;
          state <= ST_VEC_CP;
        end
        ST_VEC_CP: begin
          vector[7:0] <= bus_rdata;
          vector_valid <= 1'b1;
          busy <= 1'b0;
          state <= ST_IDLE;
        end
        default: begin
          busy <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== logic/cod_consts.vh ====
// Constants shared by the opcode decoder and the bus cycle engine.
// Assumes inclusion by bare name from files under logic/.
`ifndef COD_CONSTS_VH
`define COD_CONSTS_VH
// Operation classes
`define COD_CL_OTHER        5'h00
`define COD_CL_TBS_BRANCH   5'h01
`define COD_CL_TBC_BRANCH   5'h02
`define COD_CL_BIT_SET      5'h03
`define COD_CL_BIT_CLEAR    5'h04
`define COD_CL_BR_ALWAYS    5'h05
`define COD_CL_BR_COND      5'h06
`define COD_CL_MULTIPLY     5'h07
`define COD_CL_DIVIDE       5'h08
`define COD_CL_BG_DEBUG     5'h09
`define COD_CL_SW_INT       5'h0a
`define COD_CL_STOP         5'h0b
`define COD_CL_WAIT         5'h0c
`define COD_CL_IDXL_TO_ACC  5'h0d
`define COD_CL_DEC_BR_NZ    5'h0e
`define COD_CL_DECA_BR_NZ   5'h0f
`define COD_CL_MEM_MOVE     5'h10
`define COD_CL_REG_MEM      5'h11
`define COD_CL_PREFIX       5'h12
`define COD_CL_ILLEGAL      5'h13
// Addressing modes
`define COD_AM_INH          4'h0
`define COD_AM_IMM          4'h1
`define COD_AM_DIR          4'h2
`define COD_AM_EXT          4'h3
`define COD_AM_IX2          4'h4
`define COD_AM_IX1          4'h5
`define COD_AM_IX           4'h6
`define COD_AM_REL          4'h7
`define COD_AM_IXP          4'h8
`define COD_AM_IX1P         4'h9
`define COD_AM_DD           4'ha
`define COD_AM_DIXP         4'hb
`define COD_AM_IMD          4'hc
`define COD_AM_IXPD         4'hd
// Bus cycle kinds
`define COD_CY_FREE         3'h0
`define COD_CY_PROG         3'h1
`define COD_CY_READ         3'h2
`define COD_CY_WRITE        3'h3
`define COD_CY_PUSH         3'h4
`define COD_CY_POP          3'h5
`define COD_CY_VECTOR       3'h6
// Fixed values
`define COD_PREFIX_OP       8'h9e
`define COD_VEC_PAGE        8'hff
`define COD_RST_PC          16'h0000
`define COD_RST_SP          16'h00ff
`define COD_ONE16           16'h0001
`define COD_ONE8            8'h01
`endif

// ==== logic/cod_op_table.v ====
// First-page opcode lookup: class, mode, length, cycles, bit number.
// Assumes a registered consumer; purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "cod_consts.vh"
module cod_op_table (
  input  wire [7:0] op,
  output reg  [4:0] cls,
  output reg  [3:0] mode,
  output reg  [1:0] len,
  output reg  [3:0] cyc,
  output reg        open_end,
  output wire [2:0] bit_num
);
  wire [3:0] hi = op[7:4];
  wire [3:0] lo = op[3:0];
  assign bit_num = op[3:1];

  always @* begin
    cls = `COD_CL_OTHER;
    mode = `COD_AM_INH;
    len = 2'h1;
    cyc = 4'h1;
    open_end = 1'b0;
    case (hi)
      4'h0: begin
        cls = op[0] ? `COD_CL_TBC_BRANCH : `COD_CL_TBS_BRANCH;
        mode = `COD_AM_DIR; len = 2'h3; cyc = 4'h5;
      end
      4'h1: begin
        cls = op[0] ? `COD_CL_BIT_CLEAR : `COD_CL_BIT_SET;
        mode = `COD_AM_DIR; len = 2'h2; cyc = 4'h5;
      end
      4'h2: begin
        cls = (lo == 4'h0) ? `COD_CL_BR_ALWAYS : `COD_CL_BR_COND;
        mode = `COD_AM_REL; len = 2'h2; cyc = 4'h3;
      end
      4'h3: begin
        mode = `COD_AM_DIR; len = 2'h2; cyc = 4'h5;
        case (lo)
          4'h1: len = 2'h3;
          4'h2: begin mode = `COD_AM_EXT; len = 2'h3; end
          4'h5: cyc = 4'h4;
          4'hb: begin
            cls = `COD_CL_DEC_BR_NZ; len = 2'h3; cyc = 4'h7;
          end
          4'hd: cyc = 4'h4;
          4'he: begin mode = `COD_AM_EXT; len = 2'h3; cyc = 4'h6; end
          default: ;
        endcase
      end
      4'h4, 4'h5: begin
        case (lo)
          4'h1: begin mode = `COD_AM_IMM; len = 2'h3; cyc = 4'h4; end
          4'h2: begin
            cls = hi[0] ? `COD_CL_DIVIDE : `COD_CL_MULTIPLY;
            cyc = hi[0] ? 4'h6 : 4'h5;
          end
          4'h5: begin
            mode = hi[0] ? `COD_AM_DIR : `COD_AM_IMM;
            len = hi[0] ? 2'h2 : 2'h3;
            cyc = hi[0] ? 4'h4 : 4'h3;
          end
          4'hb: begin
            cls = hi[0] ? `COD_CL_OTHER : `COD_CL_DECA_BR_NZ;
            len = 2'h2; cyc = 4'h4;
          end
          4'he: begin
            cls = `COD_CL_MEM_MOVE; cyc = 4'h5;
            mode = hi[0] ? `COD_AM_DIXP : `COD_AM_DD;
            len = hi[0] ? 2'h2 : 2'h3;
          end
          default: ;
        endcase
      end
      4'h6, 4'h7: begin
        mode = hi[0] ? `COD_AM_IX : `COD_AM_IX1;
        len = hi[0] ? 2'h1 : 2'h2;
        cyc = hi[0] ? 4'h4 : 4'h5;
        case (lo)
          4'h1: begin
            mode = hi[0] ? `COD_AM_IXP : `COD_AM_IX1P;
            len = hi[0] ? 2'h2 : 2'h3; cyc = 4'h5;
          end
          4'h2: begin mode = `COD_AM_INH; len = 2'h1; cyc = 4'h1; end
          4'h5: begin
            mode = hi[0] ? `COD_AM_DIR : `COD_AM_IMM;
            len = hi[0] ? 2'h2 : 2'h3;
            cyc = hi[0] ? 4'h5 : 4'h3;
          end
          4'hb: begin
            len = hi[0] ? 2'h2 : 2'h3;
            cyc = hi[0] ? 4'h6 : 4'h7;
          end
          4'hd: cyc = hi[0] ? 4'h3 : 4'h4;
          4'he: begin
            cls = `COD_CL_MEM_MOVE;
            mode = hi[0] ? `COD_AM_IXPD : `COD_AM_IMD;
            len = hi[0] ? 2'h2 : 2'h3;
            cyc = hi[0] ? 4'h5 : 4'h4;
          end
          default: ;
        endcase
      end
      4'h8: begin
        case (lo)
          4'h0: cyc = 4'h9;
          4'h1: cyc = 4'h4;
          4'h2: begin
            cls = `COD_CL_BG_DEBUG; cyc = 4'h5; open_end = 1'b1;
          end
          4'h3: begin cls = `COD_CL_SW_INT; cyc = 4'hb; end
          4'h6, 4'h8, 4'ha: cyc = 4'h3;
          4'h7, 4'h9, 4'hb: cyc = 4'h2;
          4'hd: cls = `COD_CL_ILLEGAL;
          4'he: begin
            cls = `COD_CL_STOP; cyc = 4'h2; open_end = 1'b1;
          end
          4'hf: begin
            cls = `COD_CL_WAIT; cyc = 4'h2; open_end = 1'b1;
          end
          default: ;
        endcase
      end
      4'h9: begin
        if (lo < 4'h4) begin
          cls = `COD_CL_BR_COND; mode = `COD_AM_REL; len = 2'h2; cyc = 4'h3;
        end else if (lo == 4'h4 || lo == 4'h5) begin
          cyc = 4'h2;
        end else if (lo == 4'h6) begin
          mode = `COD_AM_EXT; len = 2'h3; cyc = 4'h5;
        end else if (lo == 4'he) begin
          cls = `COD_CL_PREFIX; cyc = 4'h0;
        end else if (lo == 4'hf) begin
          cls = `COD_CL_IDXL_TO_ACC;
        end
      end
      default: begin
        cls = `COD_CL_REG_MEM;
        case (hi)
          4'ha: begin mode = `COD_AM_IMM; len = 2'h2; cyc = 4'h2; end
          4'hb: begin mode = `COD_AM_DIR; len = 2'h2; cyc = 4'h3; end
          4'hc: begin mode = `COD_AM_EXT; len = 2'h3; cyc = 4'h4; end
          4'hd: begin mode = `COD_AM_IX2; len = 2'h3; cyc = 4'h4; end
          4'he: begin mode = `COD_AM_IX1; len = 2'h2; cyc = 4'h3; end
          default: begin mode = `COD_AM_IX; len = 2'h1; cyc = 4'h3; end
        endcase
        if (lo == 4'hd) begin
          cyc = cyc + 4'h2;
          if (hi == 4'ha) begin
            mode = `COD_AM_REL; cyc = 4'h5;
          end
        end
        if (hi == 4'hf && (lo == 4'h7 || lo == 4'hf))
          cyc = 4'h2;
        if (op == 8'hac)
          cls = `COD_CL_ILLEGAL;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== tb/cod_mem_model.sv ====
// Program and data memory beside the decoder's bus.
// Assumes reads are combinational from bus_addr; writes land on the edge.
`timescale 1ns/100ps
`default_nettype none
module cod_mem_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic        bus_xfer,
  input  wire logic [7:0]  bus_wdata,
  output wire logic [7:0]  bus_rdata
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
  end
  // Inverse when not reading, so stale data never looks right
  assign bus_rdata = bus_rd ? mem[bus_addr] : ~mem[bus_addr];
  always @(posedge core_clk) begin
    if (bus_wr && bus_xfer) mem[bus_addr] <= bus_wdata;
  end
endmodule
`default_nettype wire

// ==== tb/cod_decode_asserts.sv ====
// Port-level checks for the decoder and bus cycle engine.
// Assumes a bind onto cod_decode; one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "cod_consts.vh"
module cod_decode_asserts (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        op_valid,
  input wire logic [7:0]  op_byte,
  input wire logic        page2_pending,
  input wire logic [4:0]  dec_class,
  input wire logic [1:0]  dec_len,
  input wire logic [3:0]  dec_cycles,
  input wire logic [2:0]  dec_bit,
  input wire logic        dec_illegal,
  input wire logic        cyc_start,
  input wire logic [2:0]  cyc_kind,
  input wire logic [7:0]  cyc_wdata,
  input wire logic [7:0]  vec_offset,
  input wire logic        pc_load,
  input wire logic        sp_load,
  input wire logic [7:0]  bus_rdata,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic        bus_xfer,
  input wire logic [7:0]  bus_wdata,
  input wire logic        busy,
  input wire logic [7:0]  rdata,
  input wire logic        rdata_valid,
  input wire logic        vector_valid,
  input wire logic [15:0] pc,
  input wire logic [15:0] sp
);
  default clocking dcb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Page-one byte taken, bus request taken
  wire tk = op_valid && !page2_pending;
  wire bs = cyc_start && !busy;
  property p_tbr;
    tk && op_byte[7:4] == 4'h0 |=> dec_len == 2'd3 && dec_cycles == 4'h5
      && dec_bit == $past(op_byte[3:1]) && dec_class == ($past(op_byte[0])
      ? `COD_CL_TBC_BRANCH : `COD_CL_TBS_BRANCH);
  endproperty
  a_tbr: assert property (p_tbr) else $error("test branch decode");
  property p_bop;
    tk && op_byte[7:4] == 4'h1 |=> dec_len == 2'd2 && dec_cycles == 4'h5
      && dec_class == ($past(op_byte[0]) ? `COD_CL_BIT_CLEAR : `COD_CL_BIT_SET);
  endproperty
  a_bop: assert property (p_bop) else $error("bit op decode");
  property p_bra;
    tk && op_byte[7:4] == 4'h2 |=> dec_len == 2'd2 && dec_cycles == 4'h3;
  endproperty
  a_bra: assert property (p_bra) else $error("branch decode");
  property p_mdv;
    tk && (op_byte == 8'h42 || op_byte == 8'h52) |=>
      dec_cycles == ($past(op_byte[4]) ? 4'h6 : 4'h5) && dec_len == 2'd1;
  endproperty
  a_mdv: assert property (p_mdv) else $error("mul div decode");
  property p_pfx;
    tk && op_byte == 8'h9e |=> page2_pending && dec_class == `COD_CL_PREFIX;
  endproperty
  a_pfx: assert property (p_pfx) else $error("prefix decode");
  property p_ill;
    tk && (op_byte == 8'h8d || op_byte == 8'hac) |=> dec_illegal;
  endproperty
  a_ill: assert property (p_ill) else $error("illegal flag");
  property p_free;
    bs && cyc_kind == `COD_CY_FREE |=> bus_rd && !bus_wr && !bus_xfer;
  endproperty
  a_free: assert property (p_free) else $error("free cycle");
  property p_fetch;
    bs && cyc_kind == `COD_CY_PROG && !pc_load |=> bus_xfer
      && bus_addr == $past(pc) && pc == $past(pc) + 16'h1;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch step");
  property p_vec;
    bs && cyc_kind == `COD_CY_VECTOR |=> busy && bus_xfer
      && bus_addr == {8'hff, $past(vec_offset)} ##1 bus_xfer
      && bus_addr == {8'hff, $past(bus_addr[7:0]) + 8'h1}
      ##1 vector_valid && !busy;
  endproperty
  a_vec: assert property (p_vec) else $error("vector fetch");
  property p_push;
    bs && cyc_kind == `COD_CY_PUSH && !sp_load |=> bus_wr && bus_xfer
      && bus_addr == $past(sp) && sp == $past(sp) - 16'h1
      && bus_wdata == $past(cyc_wdata);
  endproperty
  a_push: assert property (p_push) else $error("push cycle");
  property p_rd;
    bus_xfer && bus_rd && !busy |=> rdata_valid && rdata == $past(bus_rdata);
  endproperty
  a_rd: assert property (p_rd) else $error("read byte");
endmodule
`default_nettype wire

// ==== tb/cod_decode_tb.sv ====
// Self-checking bench for the opcode decoder and bus cycle engine.
// Assumes cod_decode, the memory model and the checker compile first.
`timescale 1ns/100ps
`default_nettype none
`include "cod_consts.vh"
module cod_decode_tb;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        op_valid = 1'b0, cyc_start = 1'b0;
  logic        pc_load = 1'b0, sp_load = 1'b0;
  logic [7:0]  op_byte = 8'h0, cyc_wdata = 8'h0, vec_offset = 8'h0;
  logic [2:0]  cyc_kind = 3'h0;
  logic [15:0] cyc_addr = 16'h0, pc_value = 16'h0, sp_value = 16'h0;
  logic [7:0]  bus_rdata, bus_wdata, rdata;
  logic [4:0]  dec_class;
  logic [3:0]  dec_mode, dec_cycles;
  logic [1:0]  dec_len;
  logic [2:0]  dec_bit;
  logic        dec_valid, dec_open_end, dec_illegal, dec_page2;
  logic        page2_pending, bus_rd, bus_wr, bus_xfer, busy;
  logic        rdata_valid, vector_valid, ppm;
  logic [15:0] bus_addr, vector, pc, sp, pcm, spm;
  logic [7:0]  shd [0:65535];
  int          n_fail = 0;
  int          n_tests = 0;
  integer      seed = 32'h8b9447d8;
  logic [31:0] r;
  logic [7:0]  cl [26] = '{8'h3b, 8'h4b, 8'h42, 8'h52, 8'h82, 8'h83, 8'h8e,
    8'h8f, 8'h9f, 8'h4e, 8'h5e, 8'h6e, 8'h7e, 8'ha0, 8'hb0, 8'hc0, 8'hd0,
    8'he0, 8'hf0, 8'h8d, 8'hac, 8'h9e, 8'h9e, 8'h9e, 8'h42, 8'hbd};

  cod_decode cod_decode_inst (.*);
  cod_mem_model cod_mem_model_inst (.*);

  always #10 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Expected {known, class, mode, len, cycles} for checked page-one codes
  function automatic logic [15:0] xd(input logic [7:0] o);
    logic [14:0] v;
    casez (o)
      8'h0?: v = {o[0] ? `COD_CL_TBC_BRANCH : `COD_CL_TBS_BRANCH,
                  `COD_AM_DIR, 6'h35};
      8'h1?: v = {o[0] ? `COD_CL_BIT_CLEAR : `COD_CL_BIT_SET,
                  `COD_AM_DIR, 6'h25};
      8'h20: v = {`COD_CL_BR_ALWAYS, `COD_AM_REL, 6'h23};
      8'h2?: v = {`COD_CL_BR_COND, `COD_AM_REL, 6'h23};
      8'h3b: v = {`COD_CL_DEC_BR_NZ, `COD_AM_DIR, 6'h37};
      8'h42: v = {`COD_CL_MULTIPLY, `COD_AM_INH, 6'h15};
      8'h4b: v = {`COD_CL_DECA_BR_NZ, `COD_AM_INH, 6'h24};
      8'h4e: v = {`COD_CL_MEM_MOVE, `COD_AM_DD, 6'h35};
      8'h52: v = {`COD_CL_DIVIDE, `COD_AM_INH, 6'h16};
      8'h5e: v = {`COD_CL_MEM_MOVE, `COD_AM_DIXP, 6'h25};
      8'h6e: v = {`COD_CL_MEM_MOVE, `COD_AM_IMD, 6'h34};
      8'h7e: v = {`COD_CL_MEM_MOVE, `COD_AM_IXPD, 6'h25};
      8'h82: v = {`COD_CL_BG_DEBUG, `COD_AM_INH, 6'h15};
      8'h83: v = {`COD_CL_SW_INT, `COD_AM_INH, 6'h1b};
      8'h8e: v = {`COD_CL_STOP, `COD_AM_INH, 6'h12};
      8'h8f: v = {`COD_CL_WAIT, `COD_AM_INH, 6'h12};
      8'h9f: v = {`COD_CL_IDXL_TO_ACC, `COD_AM_INH, 6'h11};
      8'ha0: v = {`COD_CL_REG_MEM, `COD_AM_IMM, 6'h22};
      8'hb0: v = {`COD_CL_REG_MEM, `COD_AM_DIR, 6'h23};
      8'hbd: v = {`COD_CL_REG_MEM, `COD_AM_DIR, 6'h25};
      8'hc0: v = {`COD_CL_REG_MEM, `COD_AM_EXT, 6'h34};
      8'hd0: v = {`COD_CL_REG_MEM, `COD_AM_IX2, 6'h34};
      8'he0: v = {`COD_CL_REG_MEM, `COD_AM_IX1, 6'h23};
      8'hf0: v = {`COD_CL_REG_MEM, `COD_AM_IX, 6'h13};
      default: return 16'h0;
    endcase
    return {1'b1, v};
  endfunction

  task automatic dec(input logic [7:0] o);
    logic [15:0] x;
    x = xd(o);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_byte <= o;
    @(posedge core_clk);
    op_valid <= 1'b0;
    #1;
    chk("dec_valid", 32'h1, dec_valid);
    chk("page2_pending", o == 8'h9e && !ppm, page2_pending);
    if (ppm) begin
      chk("page2 byte", {1'b1, `COD_CL_OTHER}, {dec_page2, dec_class});
    end else if (o == 8'h9e) begin
      chk("prefix", {`COD_CL_PREFIX, 4'h0}, {dec_class, dec_cycles});
    end else if (o == 8'h8d || o == 8'hac) begin
      chk("illegal", {1'b1, `COD_CL_ILLEGAL}, {dec_illegal, dec_class});
    end else if (x[15]) begin
      chk("decode", {o == 8'h82 || o[7:1] == 7'h47, 1'b0, x[14:0]},
          {dec_open_end, dec_illegal, dec_class, dec_mode, dec_len,
           dec_cycles});
      if (o < 8'h20) chk("dec_bit", o[3:1], dec_bit);
    end
    ppm = o == 8'h9e && !ppm;
  endtask

  task automatic ld(input logic [15:0] p, s);
    @(posedge core_clk);
    pc_load <= 1'b1;
    pc_value <= p;
    sp_load <= 1'b1;
    sp_value <= s;
    @(posedge core_clk);
    pc_load <= 1'b0;
    sp_load <= 1'b0;
    pcm = p;
    spm = s;
  endtask

  task automatic bus(input logic [2:0] k, input logic [15:0] a,
                     input logic [7:0] d);
    logic [15:0] ea;
    logic        wr;
    @(posedge core_clk);
    cyc_start <= 1'b1;
    cyc_kind <= k;
    cyc_addr <= a;
    cyc_wdata <= d;
    vec_offset <= a[7:0];
    @(posedge core_clk);
    cyc_start <= 1'b0;
    #1;
    ea = a;
    wr = k == `COD_CY_WRITE || k == `COD_CY_PUSH;
    if (k == `COD_CY_PROG) ea = pcm++;
    if (k == `COD_CY_PUSH) ea = spm--;
    if (k == `COD_CY_POP) ea = ++spm;
    if (k == `COD_CY_VECTOR) ea = {8'hff, a[7:0]};
    chk("bus strobes", {k != `COD_CY_FREE, wr}, {bus_xfer, bus_wr});
    chk("bus_rd", !wr, bus_rd);
    if (k != `COD_CY_FREE) chk("bus_addr", ea, bus_addr);
    if (wr) begin
      chk("bus_wdata", d, bus_wdata);
      shd[ea] = d;
    end else if (k == `COD_CY_VECTOR) begin
      // Second request lands while busy and must vanish
      @(posedge core_clk);
      cyc_start <= 1'b1;
      cyc_kind <= `COD_CY_WRITE;
      #1;
      chk("vector low addr", {8'hff, a[7:0] + 8'h1}, bus_addr);
      @(posedge core_clk);
      cyc_start <= 1'b0;
      #1;
      chk("vector", {shd[ea], shd[{8'hff, a[7:0] + 8'h1}]}, vector);
      chk("vector end", 3'b100, {vector_valid, busy, bus_wr});
    end else if (k != `COD_CY_FREE) begin
      @(posedge core_clk);
      #1;
      chk("rdata", {1'b1, shd[ea]}, {rdata_valid, rdata});
    end
    chk("pc sp", {pcm, spm}, {pc, sp});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 65536; i++) shd[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
    pcm = 16'h0000;
    spm = 16'h00ff;
    ppm = 1'b0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("reset state", {pcm, spm}, {pc, sp});
    for (int i = 0; i < 48; i++) dec(i[7:0]);
    for (int i = 0; i < 6; i++) dec(cl[i]);
    for (int i = 6; i < 19; i++) dec(cl[i]);
    for (int i = 19; i < 26; i++) dec(cl[i]);
    repeat (2) bus(`COD_CY_FREE, 16'h0, 8'h0);
    repeat (3) bus(`COD_CY_PROG, 16'h0, 8'h0);
    for (int i = 0; i < 3; i++)
      bus(`COD_CY_PUSH, 16'h0, 8'ha0 + i[7:0]);
    repeat (3) bus(`COD_CY_POP, 16'h0, 8'h0);
    bus(`COD_CY_WRITE, 16'h1234, 8'h5a);
    bus(`COD_CY_READ, 16'h1234, 8'h0);
    bus(`COD_CY_VECTOR, 16'h00fe, 8'h0);
    bus(`COD_CY_VECTOR, 16'h00ff, 8'h0);
    repeat (300) begin
      r = $random(seed);
      dec(r[7:0]);
    end
    repeat (250) begin
      r = $random(seed);
      if (r[4:0] == 5'h0) ld(r[31:16], r[23:8]);
      r[2:0] = r[2:0] == 3'h7 ? `COD_CY_READ : r[2:0];
      bus(r[2:0], r[31:16], r[15:8]);
    end
    conclude;
  end

  initial begin
    #400000;
    n_fail++;
    conclude;
  end
endmodule

bind cod_decode cod_decode_asserts cod_decode_asserts_inst (.*);
`default_nettype wire
